// ### verilog/irq_front_end_cfg.svh
// constants of the interrupt request front end: indices, masks, fields
// assumes an 8-bit special register port on the 10 MHz system clock
//
// Overview of operation
// - a pending, enabled request under global enable interrupts the core.
// - four external pins, numbered zero to three, raise their own requests.
// - timer, time base, low-voltage, eeprom, serial and analog units request.
// - hardware sets each flag; only register writes change enable bits.
// - four primary, six grouped and one edge-select control register.
// - every source owns an enable and a flag; a global enable gates all.
// - each timer raises period and compare requests, each serial port one.
// - edge select: one read/write 2-bit field per pin, pin 3 top, reset 0.
// - edge field 00 disables, 01 rising, 10 falling, 11 both edges.
// - flag 1 means a request is pending; enable 1 lets its source through.
`ifndef IRQ_FRONT_END_CFG_SVH
`define IRQ_FRONT_END_CFG_SVH

`define IRQ_ADDR_W         4
`define IRQ_IDX_EDGE_SEL   4'h0
`define IRQ_IDX_PRIMARY0   4'h1
`define IRQ_IDX_PRIMARY1   4'h2
`define IRQ_IDX_PRIMARY2   4'h3
`define IRQ_IDX_PRIMARY3   4'h4
`define IRQ_IDX_GROUP0     4'h5
`define IRQ_GROUP_COUNT    6

`define IRQ_RST_BYTE       8'h00

`define IRQ_WMASK_PRIMARY0 8'h7F
`define IRQ_WMASK_PRIMARY1 8'h9F
`define IRQ_WMASK_PRIMARY2 8'h6F
`define IRQ_WMASK_PRIMARY3 8'h3F
`define IRQ_WMASK_GROUP    48'h33FF_FF33_FFFF
`define IRQ_FMASK_GROUP    24'h33_B3FF

`define IRQ_BIT_GLOBAL_EN  0
`define IRQ_BIT_EXT0_EN    1
`define IRQ_BIT_EXT1_EN    2
`define IRQ_BIT_EXT0_FLAG  4
`define IRQ_BIT_EXT1_FLAG  5
`define IRQ_BIT_CONV_FLAG  7
`define IRQ_BIT_CMP_FLAG   4
`define IRQ_BIT_TB1_FLAG   6
`define IRQ_BIT_TB0_FLAG   5
`define IRQ_BIT_EXT3_FLAG  5
`define IRQ_BIT_EXT2_FLAG  4
`define IRQ_BIT_GRP0_FLAG  5
`define IRQ_BIT_GRP1_FLAG  6
`define IRQ_BIT_GRP2_FLAG  4
`define IRQ_BIT_GRP3_FLAG  7
`define IRQ_BIT_GRP4_FLAG  6
`define IRQ_BIT_GRP5_FLAG  7
`define IRQ_BIT_STD_CMP    7
`define IRQ_BIT_STD_PER    6
`define IRQ_BIT_PTM_CMP    5
`define IRQ_BIT_PTM_PER    4
`define IRQ_BIT_SER_FLAG   7
`define IRQ_BIT_EE_FLAG    5
`define IRQ_BIT_LV_FLAG    4
`define IRQ_BIT_UART1_FLAG 5
`define IRQ_BIT_UART0_FLAG 4

`endif

// ### verilog/irq_front_end_pkg.sv
// types and shared helpers of the interrupt request front end
// assumes the constants header is compiled alongside
package irq_front_end_pkg;

    typedef logic [7:0] byte_type;

    typedef enum logic [1:0] {
        edge_off,
        edge_rise,
        edge_fall,
        edge_both
    } edge_mode_type;

    // flags sit in the high nibble, their enables in the low one
    function automatic logic nibble_pending(input byte_type r,
                                            input logic [3:0] m);
        nibble_pending = |(r[7:4] & r[3:0] & m);
    endfunction : nibble_pending

endpackage : irq_front_end_pkg

// ### verilog/irq_edge_if.sv
// carrier between the register file and the external edge detector
// assumes both ends run on the same system clock
`timescale 1ns/1ps
`default_nettype none
interface irq_edge_if;
    logic [7:0] edge_sel;
    logic [3:0] edge_evt;

    modport detector (input edge_sel, output edge_evt);
    modport owner    (output edge_sel, input edge_evt);
endinterface : irq_edge_if
`default_nettype wire

// ### verilog/ext_edge_detect.sv
// synchronises the external interrupt pins and flags qualifying edges
// assumes pins are asynchronous to i_clk; events are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module ext_edge_detect #(
    parameter int PINS = 4
) (
    input  wire logic            i_clk,
    input  wire logic            i_sys_rst,
    input  wire logic [PINS-1:0] i_pins,
    irq_edge_if.detector         edge_port
);
    logic [PINS-1:0] meta_reg;
    logic [PINS-1:0] sync_reg;
    logic [PINS-1:0] prev_reg;

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            meta_reg <= '0;
            sync_reg <= '0;
            prev_reg <= '0;
        end else begin
            meta_reg <= i_pins;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    always_comb begin
        for (int n = 0; n < PINS; n++) begin
            case (irq_front_end_pkg::edge_mode_type'(
                      edge_port.edge_sel[2*n +: 2]))
                irq_front_end_pkg::edge_rise:
                    edge_port.edge_evt[n] = sync_reg[n] & ~prev_reg[n];
                irq_front_end_pkg::edge_fall:
                    edge_port.edge_evt[n] = ~sync_reg[n] & prev_reg[n];
                irq_front_end_pkg::edge_both:
                    edge_port.edge_evt[n] = sync_reg[n] ^ prev_reg[n];
                default:
                    edge_port.edge_evt[n] = 1'b0;
            endcase
        end
    end
endmodule : ext_edge_detect
`default_nettype wire

// ### verilog/group_flag_merge.sv
// derives the grouped request flags from the grouped control registers
// assumes the grouped registers are presented packed, group 0 lowest
`timescale 1ns/1ps
`default_nettype none
`include "irq_front_end_cfg.svh"
module group_flag_merge #(
    parameter int GROUPS = `IRQ_GROUP_COUNT
) (
    input  wire logic                i_clk,
    input  wire logic                i_sys_rst,
    input  wire logic [8*GROUPS-1:0] i_group_regs,
    input  wire logic [4*GROUPS-1:0] i_flag_masks,
    output logic      [GROUPS-1:0]   o_group_flag
);
    logic [GROUPS-1:0] group_next;

    always_comb begin
        for (int g = 0; g < GROUPS; g++) begin
            group_next[g] = irq_front_end_pkg::nibble_pending(
                i_group_regs[8*g +: 8], i_flag_masks[4*g +: 4]);
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_group_flag <= '0;
        end else begin
            o_group_flag <= group_next;
        end
    end
endmodule : group_flag_merge
`default_nettype wire

// ### verilog/irq_request_front_end.sv
// interrupt request front end: edge select, primary and grouped control
// registers on an 8-bit special register port, and the core request
// assumes peripheral events are one-cycle pulses on i_clk
`timescale 1ns/1ps
`default_nettype none
`include "irq_front_end_cfg.svh"
module irq_request_front_end (
    input  wire logic                   i_clk,
    input  wire logic                   i_sys_rst,
    input  wire logic [`IRQ_ADDR_W-1:0] i_reg_addr,
    input  wire logic                   i_reg_wr,
    input  wire logic [7:0]             i_reg_wdata,
    output logic      [7:0]             o_reg_rdata,
    input  wire logic [3:0]             i_ext_irq_pins,
    input  wire logic [1:0]             i_std_timer_period,
    input  wire logic [1:0]             i_std_timer_compare,
    input  wire logic [3:0]             i_per_timer_period,
    input  wire logic [3:0]             i_per_timer_compare,
    input  wire logic [1:0]             i_timebase_evt,
    input  wire logic                   i_lowvolt_evt,
    input  wire logic                   i_eeprom_evt,
    input  wire logic                   i_serial_if_evt,
    input  wire logic [1:0]             i_serial_port_evt,
    input  wire logic                   i_comparator_evt,
    input  wire logic                   i_converter_evt,
    output logic                        o_cpu_irq
);
    localparam int GROUPS = `IRQ_GROUP_COUNT;

    irq_front_end_pkg::byte_type edge_select_reg;
    irq_front_end_pkg::byte_type primary_reg [4];
    irq_front_end_pkg::byte_type group_reg   [GROUPS];
    irq_front_end_pkg::byte_type primary_set [4];
    irq_front_end_pkg::byte_type group_set   [GROUPS];
    irq_front_end_pkg::byte_type primary_view [4];
    irq_front_end_pkg::byte_type read_next;
    irq_front_end_pkg::byte_type primary_wmask [4];

    logic [8*GROUPS-1:0] group_packed;
    logic [8*GROUPS-1:0] group_wmask;
    logic [4*GROUPS-1:0] group_fmask;
    logic [GROUPS-1:0]   group_flag;
    logic                pending;
    logic                irq_next;

    irq_edge_if edge_link ();

    // write-to-register index helpers
    function automatic logic hit(input logic [`IRQ_ADDR_W-1:0] idx);
        hit = i_reg_wr && (i_reg_addr == idx);
    endfunction : hit

    assign primary_wmask[0] = `IRQ_WMASK_PRIMARY0;
    assign primary_wmask[1] = `IRQ_WMASK_PRIMARY1;
    assign primary_wmask[2] = `IRQ_WMASK_PRIMARY2;
    assign primary_wmask[3] = `IRQ_WMASK_PRIMARY3;
    assign group_wmask      = `IRQ_WMASK_GROUP;
    assign group_fmask      = `IRQ_FMASK_GROUP;

    // external pins: edge selection leaves, events come back
    assign edge_link.edge_sel = edge_select_reg;

    ext_edge_detect #(
        .PINS      (4)
    ) u_edge (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_pins    (i_ext_irq_pins),
        .edge_port (edge_link.detector)
    );

    always_comb begin
        for (int g = 0; g < GROUPS; g++) begin
            group_packed[8*g +: 8] = group_reg[g];
        end
    end

    group_flag_merge #(
        .GROUPS       (GROUPS)
    ) u_group (
        .i_clk        (i_clk),
        .i_sys_rst    (i_sys_rst),
        .i_group_regs (group_packed),
        .i_flag_masks (group_fmask),
        .o_group_flag (group_flag)
    );

    // hardware set vectors for the primary registers
    always_comb begin
        for (int r = 0; r < 4; r++) begin
            primary_set[r] = `IRQ_RST_BYTE;
        end
        primary_set[0][`IRQ_BIT_EXT0_FLAG] = edge_link.edge_evt[0];
        primary_set[0][`IRQ_BIT_EXT1_FLAG] = edge_link.edge_evt[1];
        primary_set[1][`IRQ_BIT_CONV_FLAG] = i_converter_evt;
        primary_set[1][`IRQ_BIT_CMP_FLAG]  = i_comparator_evt;
        primary_set[2][`IRQ_BIT_TB0_FLAG]  = i_timebase_evt[0];
        primary_set[2][`IRQ_BIT_TB1_FLAG]  = i_timebase_evt[1];
        primary_set[3][`IRQ_BIT_EXT2_FLAG] = edge_link.edge_evt[2];
        primary_set[3][`IRQ_BIT_EXT3_FLAG] = edge_link.edge_evt[3];
    end

    // hardware set vectors for the grouped registers
    always_comb begin
        for (int g = 0; g < GROUPS; g++) begin
            group_set[g] = `IRQ_RST_BYTE;
        end
        for (int t = 0; t < 2; t++) begin
            group_set[t][`IRQ_BIT_STD_CMP] = i_std_timer_compare[t];
            group_set[t][`IRQ_BIT_STD_PER] = i_std_timer_period[t];
            group_set[t][`IRQ_BIT_PTM_CMP] = i_per_timer_compare[t];
            group_set[t][`IRQ_BIT_PTM_PER] = i_per_timer_period[t];
        end
        group_set[2][`IRQ_BIT_PTM_CMP]    = i_per_timer_compare[2];
        group_set[2][`IRQ_BIT_PTM_PER]    = i_per_timer_period[2];
        group_set[3][`IRQ_BIT_SER_FLAG]   = i_serial_if_evt;
        group_set[3][`IRQ_BIT_EE_FLAG]    = i_eeprom_evt;
        group_set[3][`IRQ_BIT_LV_FLAG]    = i_lowvolt_evt;
        group_set[4][`IRQ_BIT_PTM_CMP]    = i_per_timer_compare[3];
        group_set[4][`IRQ_BIT_PTM_PER]    = i_per_timer_period[3];
        group_set[5][`IRQ_BIT_UART1_FLAG] = i_serial_port_evt[1];
        group_set[5][`IRQ_BIT_UART0_FLAG] = i_serial_port_evt[0];
    end

    // edge select: plain read/write byte
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            edge_select_reg <= `IRQ_RST_BYTE;
        end else if (hit(`IRQ_IDX_EDGE_SEL)) begin
            edge_select_reg <= i_reg_wdata;
        end
    end

    // primary registers: a hardware set in the same cycle as a software
    // clear wins, so no event is lost to a read-modify-write
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            for (int r = 0; r < 4; r++) begin
                primary_reg[r] <= `IRQ_RST_BYTE;
            end
        end else begin
            for (int r = 0; r < 4; r++) begin
                if (hit(`IRQ_ADDR_W'(`IRQ_IDX_PRIMARY0 + r))) begin
                    primary_reg[r] <= (i_reg_wdata & primary_wmask[r])
                                      | primary_set[r];
                end else begin
                    primary_reg[r] <= primary_reg[r] | primary_set[r];
                end
            end
        end
    end

    // grouped registers, same set-over-clear treatment
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            for (int g = 0; g < GROUPS; g++) begin
                group_reg[g] <= `IRQ_RST_BYTE;
            end
        end else begin
            for (int g = 0; g < GROUPS; g++) begin
                if (hit(`IRQ_ADDR_W'(`IRQ_IDX_GROUP0 + g))) begin
                    group_reg[g] <= (i_reg_wdata & group_wmask[8*g +: 8])
                                    | group_set[g];
                end else begin
                    group_reg[g] <= group_reg[g] | group_set[g];
                end
            end
        end
    end

    // primary registers as software sees them: group flags are derived
    always_comb begin
        for (int r = 0; r < 4; r++) begin
            primary_view[r] = primary_reg[r];
        end
        primary_view[1][`IRQ_BIT_GRP0_FLAG] = group_flag[0];
        primary_view[1][`IRQ_BIT_GRP1_FLAG] = group_flag[1];
        primary_view[2][`IRQ_BIT_GRP2_FLAG] = group_flag[2];
        primary_view[2][`IRQ_BIT_GRP3_FLAG] = group_flag[3];
        primary_view[3][`IRQ_BIT_GRP4_FLAG] = group_flag[4];
        primary_view[3][`IRQ_BIT_GRP5_FLAG] = group_flag[5];
    end

    // any primary source with flag and enable both set
    always_comb begin
        pending = (primary_reg[0][`IRQ_BIT_EXT0_FLAG]
                   & primary_reg[0][`IRQ_BIT_EXT0_EN])
                | (primary_reg[0][`IRQ_BIT_EXT1_FLAG]
                   & primary_reg[0][`IRQ_BIT_EXT1_EN]);
        for (int r = 1; r < 4; r++) begin
            pending = pending | irq_front_end_pkg::nibble_pending(
                primary_view[r], 4'hF);
        end
        irq_next = pending & primary_reg[0][`IRQ_BIT_GLOBAL_EN];
    end

    // level request to the core; it stays up until software clears the
    // flag, an enable, or the global enable
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_cpu_irq <= 1'b0;
        end else begin
            o_cpu_irq <= irq_next;
        end
    end

    // read mux, index map of eleven registers; unmapped reads as zero
    always_comb begin
        read_next = `IRQ_RST_BYTE;
        if (i_reg_addr == `IRQ_IDX_EDGE_SEL) begin
            read_next = edge_select_reg;
        end
        for (int r = 0; r < 4; r++) begin
            if (i_reg_addr == `IRQ_ADDR_W'(`IRQ_IDX_PRIMARY0 + r)) begin
                read_next = primary_view[r];
            end
        end
        for (int g = 0; g < GROUPS; g++) begin
            if (i_reg_addr == `IRQ_ADDR_W'(`IRQ_IDX_GROUP0 + g)) begin
                read_next = group_reg[g];
            end
        end
    end

    // registered read keeps the data port glitch-free; costs one cycle
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_reg_rdata <= `IRQ_RST_BYTE;
        end else begin
            o_reg_rdata <= read_next;
        end
    end

endmodule : irq_request_front_end
`default_nettype wire

// ### sim/irq_front_end_props.sv
// checker of the interrupt request front end, top-level ports only
// assumes binding onto irq_request_front_end, one clock domain
`timescale 1ns/1ps
`default_nettype none
module irq_front_end_props (
    input wire logic       i_clk,
    input wire logic       i_sys_rst,
    input wire logic [3:0] i_reg_addr,
    input wire logic       i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] o_reg_rdata,
    input wire logic       o_cpu_irq
);
    logic glob_reg;

    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    // shadow of the global enable: only software writes may move it
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst)
            glob_reg <= 1'b0;
        else if (i_reg_wr && i_reg_addr == 4'h1)
            glob_reg <= i_reg_wdata[0];
    end

    a_unmapped_reads: assert property (
        i_reg_addr >= 4'hB |=> o_reg_rdata == 8'h00)
        else $error("unmapped index read nonzero");
    a_top_bit_zero: assert property (
        i_reg_addr == 4'h1 |=> !o_reg_rdata[7])
        else $error("unimplemented bit read as one");
    a_edge_sel_write: assert property (
        (i_reg_wr && i_reg_addr == 4'h0) ##1 (!i_reg_wr && i_reg_addr == 4'h0)
        |=> o_reg_rdata == $past(i_reg_wdata, 2))
        else $error("edge select readback differs");
    a_enable_write: assert property (
        (i_reg_wr && i_reg_addr inside {[4'h1:4'h4]}) ##1
        (!i_reg_wr && $stable(i_reg_addr))
        |=> o_reg_rdata[3:0] == $past(i_reg_wdata[3:0], 2))
        else $error("enable bits differ from write");
    a_enable_hold: assert property (
        (!i_reg_wr && i_reg_addr inside {[4'h1:4'hA]}) ##1 $stable(i_reg_addr)
        |=> $stable(o_reg_rdata[3:0]))
        else $error("enable bits moved without a write");
    a_reset_clear: assert property (
        $fell(i_sys_rst) |-> o_reg_rdata == 8'h00 && !o_cpu_irq)
        else $error("outputs not clear after reset");
    a_no_global: assert property (
        !glob_reg && !$past(glob_reg) |-> !o_cpu_irq)
        else $error("core request without global enable");
    a_rise_global: assert property (
        $rose(o_cpu_irq) |-> $past(glob_reg))
        else $error("core request rose while global off");
endmodule : irq_front_end_props

bind irq_request_front_end irq_front_end_props u_irq_front_end_props (
    .i_clk      (i_clk),
    .i_sys_rst  (i_sys_rst),
    .i_reg_addr (i_reg_addr),
    .i_reg_wr   (i_reg_wr),
    .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata),
    .o_cpu_irq  (o_cpu_irq)
);
`default_nettype wire

// ### sim/irq_event_source.sv
// model of the peripheral event sources feeding the front end
// assumes the caller holds each fire bit for exactly one clock
`timescale 1ns/1ps
`default_nettype none
module irq_event_source (
    input  wire logic [20:0] i_fire,
    output logic      [1:0]  o_std_per,
    output logic      [1:0]  o_std_cmp,
    output logic      [3:0]  o_per_per,
    output logic      [3:0]  o_per_cmp,
    output logic      [1:0]  o_timebase,
    output logic             o_lowvolt,
    output logic             o_eeprom,
    output logic             o_serial_if,
    output logic      [1:0]  o_serial_port,
    output logic             o_comparator,
    output logic             o_converter
);
    // one bit per source, so a scenario can fire any single event
    assign {o_converter, o_comparator, o_timebase, o_serial_port,
            o_serial_if, o_eeprom, o_lowvolt, o_per_cmp, o_per_per,
            o_std_cmp, o_std_per} = i_fire;
endmodule : irq_event_source
`default_nettype wire

// ### sim/irq_request_front_end_tb.sv
// self-checking bench of the interrupt request front end
// assumes design, checker and event source model compiled first
`timescale 1ns/1ps
`default_nettype none
module irq_request_front_end_tb;
    logic        clk, rst, wr, smp, smp_irq, irq;
    logic [3:0]  addr, pins, ptp, ptc;
    logic [7:0]  wdata, rdata, d, got;
    logic [20:0] fire;
    logic [1:0]  stp, stc, tbe, spe;
    logic        lowvolt_irq_enable, eee, sie, cpe, cve;
    logic [7:0]  exp_q[$];
    int          err_total, check_count, seed, i, b, g, fi, fb;
    int ridx[21] = '{5,6,5,6,5,6,7,9,5,6,7,9,8,8,8,10,10,3,3,2,2};
    int rbit[21] = '{6,6,7,7,4,4,4,4,5,5,5,5,4,5,7,4,5,5,6,4,7};
    int grp[21]  = '{0,1,0,1,0,1,2,4,0,1,2,4,3,3,3,5,5,6,6,6,6};
    int gidx[6]  = '{2,2,3,3,4,4};
    int gen[6]   = '{1,2,0,3,2,3};
    logic [7:0] wm[11] = '{8'hFF, 8'h7F, 8'h9F, 8'h6F, 8'h3F, 8'hFF,
                           8'hFF, 8'h33, 8'hFF, 8'hFF, 8'h33};

    irq_request_front_end u_irq_request_front_end (
        .i_clk(clk), .i_sys_rst(rst), .i_reg_addr(addr), .i_reg_wr(wr),
        .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_ext_irq_pins(pins),
        .i_std_timer_period(stp), .i_std_timer_compare(stc),
        .i_per_timer_period(ptp), .i_per_timer_compare(ptc),
        .i_timebase_evt(tbe), .i_lowvolt_evt(lowvolt_irq_enable), .i_eeprom_evt(eee),
        .i_serial_if_evt(sie), .i_serial_port_evt(spe),
        .i_comparator_evt(cpe), .i_converter_evt(cve), .o_cpu_irq(irq));

    irq_event_source u_irq_event_source (
        .i_fire(fire), .o_std_per(stp), .o_std_cmp(stc), .o_per_per(ptp),
        .o_per_cmp(ptc), .o_timebase(tbe), .o_lowvolt(lowvolt_irq_enable),
        .o_eeprom(eee), .o_serial_if(sie), .o_serial_port(spe),
        .o_comparator(cpe), .o_converter(cve));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
        @(negedge clk);
        addr = a;
        wdata = v;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask : wr_reg

    // read data is registered, so the note is checked one clock later
    task automatic look(input logic [3:0] a, input logic k,
                        input logic [7:0] e);
        @(negedge clk);
        addr = a;
        smp_irq = k;
        exp_q.push_back(e);
        smp <= 1'b1;
        @(negedge clk);
        smp <= 1'b0;
    endtask : look

    always @(negedge clk) begin
        if (smp) begin
            got = smp_irq ? {7'h00, irq} : rdata;
            check_count++;
            if (got !== exp_q[0]) begin
                err_total++;
                $display("Error at %0t: got %h expected %h", $time, got,
                         exp_q[0]);
            end
            void'(exp_q.pop_front());
        end
    end

    task automatic wrap_up;
        if (err_total == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : wrap_up

    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        wrap_up();
    end

    initial begin
        seed = 19;
        rst = 1'b1;
        wr = 1'b0;
        smp = 1'b0;
        smp_irq = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
        pins = 4'h0;
        fire = 21'h0_0000;
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        for (int a = 0; a < 16; a++)
            look(4'(a), 1'b0, 8'h00);
        for (int a = 0; a < 16; a++) begin
            d = 8'($random(seed));
            wr_reg(4'(a), d);
            look(4'(a), 1'b0, (a < 11) ? (d & wm[a]) : 8'h00);
            wr_reg(4'(a), 8'h00);
        end
        for (int p = 0; p < 4; p++)
            for (int m = 0; m < 4; m++) begin
                fi = (p < 2) ? 1 : 4;
                fb = 4 + p % 2;
                wr_reg(4'h0, 8'(m << (2 * p)));
                pins[p] = 1'b1;
                repeat (5) @(negedge clk);
                look(4'(fi), 1'b0, {7'h00, m[0]} << fb);
                wr_reg(4'(fi), 8'h00);
                pins[p] = 1'b0;
                repeat (5) @(negedge clk);
                look(4'(fi), 1'b0, {7'h00, m[1]} << fb);
                wr_reg(4'(fi), 8'h00);
            end
        for (int e = 0; e < 21; e++) begin
            i = ridx[e];
            b = rbit[e];
            g = grp[e];
            @(negedge clk);
            fire = 21'h0_0001 << e;
            @(negedge clk);
            fire = 21'h0_0000;
            look(4'(i), 1'b0, 8'h01 << b);
            if (g < 6)
                look(4'(gidx[g]), 1'b0, 8'h00);
            // global on first: a set flag with its enable off must not pass
            wr_reg(4'h1, 8'h01);
            repeat (2) @(negedge clk);
            look(4'h0, 1'b1, 8'h00);
            wr_reg(4'(i), 8'h11 << (b - 4));
            if (g < 6)
                wr_reg(4'(gidx[g]), 8'h01 << gen[g]);
            repeat (2) @(negedge clk);
            if (g < 6)
                look(4'(gidx[g]), 1'b0, 8'h11 << gen[g]);
            look(4'h0, 1'b1, 8'h01);
            wr_reg(4'h1, 8'h00);
            repeat (2) @(negedge clk);
            look(4'h0, 1'b1, 8'h00);
            wr_reg(4'(i), 8'h00);
            if (g < 6)
                wr_reg(4'(gidx[g]), 8'h00);
        end
        repeat (4) @(negedge clk);
        wrap_up();
    end
endmodule : irq_request_front_end_tb
`default_nettype wire
